// [verilog/ttpg_top.sv]
// t1/e1 timing pulse generator: loop, clock dividers, frame pulses, regs
`timescale 1ns/10ps
`include "ttpg_defs.svh"

// Summary of operation
// [R1] 2M frame pulse low 244 ns per frame
// [R2] receive and transmit sync high 488 ns
// [R3] general frame pulse high 122 ns
// [R4] continuous 1.544 MHz clock output
// [R5] continuous 2.048 and 4.096 MHz clocks
// [R6] continuous 8.192 and 16.384 MHz clocks
// [R7] continuous 19.44 MHz clock output
// [R8] continuous 6.312 MHz clock output
// [R9] lock output high only when frequency locked
// [R10] fast acquire enable shortens lock time
// [R11] impairment flag high when forced to freerun
// [R12] mode sampled on general frame pulse rise
// [R13] only reference falling edges are used
// [R14] rate select: 00 oc3, 01 8k, 10 t1, 11 2m
// [R15] reset after any rate select change
// [R16] mode low normal, high freerun
// [R17] reset levels: clocks high except 16.384 MHz and ds2 low, sync low, oc3 runs
// [R18] freerun ignores reference, master clock only
// [R19] frame pulses derived from 16.384 MHz clock
module ttpg_top import ttpg_pkg::*; #(
  parameter int REF_PERIOD_CYC = `TTPG_REF_PERIOD_CYC
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output ttpg_resp_t s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output ttpg_resp_t s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic ref_in,
  output logic clk_t1_out,
  output logic clk_2m_out,
  output logic clk_4m_out,
  output logic clk_8m_out,
  output logic clk_16m_out,
  output logic clk_oc3_out = 1'b0,
  output logic clk_ds2_out,
  output logic frame_pulse_2m_n_out,
  output logic receive_sync_pulse_out,
  output logic transmit_sync_pulse_out,
  output logic frame_pulse_general_out,
  output logic frame_pulse_8m_n_out,
  output logic lock_out,
  output logic impairment_flag_out,
  output logic irq_out
);
  // the watchdog is 17 bits wide and must see a sane frame period
  if (REF_PERIOD_CYC < 64 || REF_PERIOD_CYC > 65535) begin : g_bad_period
    $error("ttpg_top: REF_PERIOD_CYC out of range");
  end

  localparam logic [16:0] PER_MAX =
    17'(REF_PERIOD_CYC + REF_PERIOD_CYC / 4);
  localparam logic [16:0] PER_MIN =
    17'(REF_PERIOD_CYC - REF_PERIOD_CYC / 4);

  // --------------------------------------------------------------------------
  // register bus slave
  // --------------------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic next_aw_got;
  logic next_w_got;
  logic next_rvalid;
  logic [3:0] ctrl;
  logic [2:0] int_stat;
  logic [2:0] int_mask;
  logic [2:0] next_int_stat;
  logic [2:0] int_event;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  assign aw_hs = s_axi_awvalid_in & s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in & s_axi_wready_out;
  assign ar_hs = s_axi_arvalid_in & s_axi_arready_out;
  // address and data may come in either order; answer waits for both
  assign do_write = aw_got & w_got & ~s_axi_bvalid_out;
  assign next_aw_got = do_write ? 1'b0 : (aw_got | aw_hs);
  assign next_w_got = do_write ? 1'b0 : (w_got | w_hs);
  assign next_rvalid = ar_hs | (s_axi_rvalid_out & ~s_axi_rready_in);
  assign wr_ok = (aw_addr == `TTPG_OFS_CTRL) ||
                 (aw_addr == `TTPG_OFS_STATUS) ||
                 (aw_addr == `TTPG_OFS_INT_STAT) ||
                 (aw_addr == `TTPG_OFS_INT_MASK) ||
                 (aw_addr == `TTPG_OFS_TRIM);

  // hold each write channel until its partner arrives
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready_out <= ~next_aw_got;
      s_axi_wready_out <= ~next_w_got;
      if (aw_hs) begin
        aw_addr <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (w_hs) begin
        w_data <= s_axi_wdata_in;
        w_lane0 <= s_axi_wstrb_in[0];
      end
    end
  end

  // write response; unmapped addresses answer with a slave error
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `TTPG_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_ok ? `TTPG_RESP_OKAY : `TTPG_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // read path: one read in flight, data one cycle after the address
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= `TTPG_RESP_OKAY;
    end else begin
      s_axi_arready_out <= ~next_rvalid;
      s_axi_rvalid_out <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata_out <= rd_word;
        s_axi_rresp_out <= rd_ok ? `TTPG_RESP_OKAY : `TTPG_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // nco bank: one common trim keeps all clock families in step
  // --------------------------------------------------------------------------
  ttpg_trim_t trim;
  ttpg_nco_if nco_16m ();
  ttpg_nco_if nco_t1 ();
  ttpg_nco_if nco_ds2 ();
  ttpg_nco_if nco_oc3 ();

  assign nco_16m.trim = trim;
  assign nco_t1.trim = trim;
  assign nco_ds2.trim = trim;
  assign nco_oc3.trim = trim;

  ttpg_nco #(.INC(`TTPG_INC_16M)) u_nco_16m (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .nco(nco_16m.core)
  );
  ttpg_nco #(.INC(`TTPG_INC_T1)) u_nco_t1 (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .nco(nco_t1.core)
  );
  ttpg_nco #(.INC(`TTPG_INC_DS2)) u_nco_ds2 (
    .clk_in(clk_in),
    .rst_in(sys_rst_in),
    .nco(nco_ds2.core)
  );
  // the oc3 oscillator ignores reset so that its clock keeps running
  ttpg_nco #(.INC(`TTPG_INC_OC3)) u_nco_oc3 (
    .clk_in(clk_in),
    .rst_in(1'b0),
    .nco(nco_oc3.core)
  );

  // --------------------------------------------------------------------------
  // output clocks and frame pulses
  // --------------------------------------------------------------------------
  logic [11:0] edge_cnt;
  logic [11:0] next_edge;
  logic mode_q;

  assign next_edge = edge_cnt + 12'h001;

  // 16.384 MHz edge counter; the 8/4/2 MHz clocks are its bits 1 to 3
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      edge_cnt <= 12'hfff; // first tick opens frame
      clk_16m_out <= 1'b0; // [R17]
      clk_8m_out <= 1'b1;
      clk_4m_out <= 1'b1;
      clk_2m_out <= 1'b1;
    end else if (nco_16m.tick) begin
      edge_cnt <= next_edge;
      clk_16m_out <= next_edge[0]; // [R6]
      clk_8m_out <= next_edge[1]; // [R6]
      clk_4m_out <= next_edge[2]; // [R5]
      clk_2m_out <= next_edge[3]; // [R5]
    end
  end

  // every pulse is decoded from the same 16.384 MHz edge count
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frame_pulse_2m_n_out <= 1'b1; // [R17]
      frame_pulse_general_out <= 1'b1;
      frame_pulse_8m_n_out <= 1'b1;
      receive_sync_pulse_out <= 1'b0;
      transmit_sync_pulse_out <= 1'b0;
    end else if (nco_16m.tick) begin // [R19]
      frame_pulse_2m_n_out <= ~(next_edge < `TTPG_F0_EDGES); // [R1]
      receive_sync_pulse_out <= next_edge < `TTPG_SYNC_EDGES; // [R2]
      transmit_sync_pulse_out <= next_edge < `TTPG_SYNC_EDGES; // [R2]
      frame_pulse_general_out <= next_edge < `TTPG_F8_EDGES; // [R3]
      frame_pulse_8m_n_out <= ~(next_edge < `TTPG_F16_EDGES);
    end
  end

  // the independent families toggle on their own nco ticks
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_t1_out <= 1'b1; // [R17]
      clk_ds2_out <= 1'b0;
    end else begin
      if (nco_t1.tick) begin
        clk_t1_out <= ~clk_t1_out; // [R4]
      end
      if (nco_ds2.tick) begin
        clk_ds2_out <= ~clk_ds2_out; // [R8]
      end
    end
  end

  // no reset: this clock runs straight through a device reset
  always_ff @(posedge clk_in) begin
    if (nco_oc3.tick) begin
      clk_oc3_out <= ~clk_oc3_out; // [R7]
    end
  end

  // mode bit is taken only as the general frame pulse rises
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_q <= 1'b0;
    end else if (nco_16m.tick && next_edge == 12'h000) begin // [R12]
      mode_q <= ctrl[`TTPG_CTRL_MODE]; // [R16]
    end
  end

  // --------------------------------------------------------------------------
  // reference prescaler: falling edges folded down to an 8 kHz tick
  // --------------------------------------------------------------------------
  logic ref_q;
  logic ref_fall;
  logic ref_tick;
  logic [11:0] pre_cnt;
  logic [11:0] pre_div;

  assign ref_fall = ref_q & ~ref_in; // [R13]

  // rate select is read live; a change needs a reset to realign
  always_comb begin
    case ({ctrl[`TTPG_CTRL_SEL_HI], ctrl[`TTPG_CTRL_SEL_LO]}) // [R14] [R15]
      2'b00: pre_div = `TTPG_DIV_OC3;
      2'b01: pre_div = `TTPG_DIV_8K;
      2'b10: pre_div = `TTPG_DIV_T1;
      2'b11: pre_div = `TTPG_DIV_2M;
      default: pre_div = `TTPG_DIV_8K;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref_q <= 1'b1;
      pre_cnt <= 12'h000;
      ref_tick <= 1'b0;
    end else begin
      ref_q <= ref_in;
      ref_tick <= 1'b0;
      if (ref_fall) begin
        if (pre_cnt >= pre_div - 12'h001) begin
          pre_cnt <= 12'h000;
          ref_tick <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 12'h001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // input impairment monitor
  // --------------------------------------------------------------------------
  logic [16:0] wd_cnt;
  logic impaired;
  logic [2:0] good_ref;
  logic period_bad;

  assign period_bad = (wd_cnt > PER_MAX) || (ref_tick && wd_cnt < PER_MIN);

  // loss of reference or a large frequency shift forces freerun
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wd_cnt <= 17'h0;
      impaired <= 1'b0;
      good_ref <= 3'h0;
    end else begin
      if (ref_tick) begin
        wd_cnt <= 17'h0;
      end else if (wd_cnt <= PER_MAX) begin
        wd_cnt <= wd_cnt + 17'h1;
      end
      if (period_bad) begin
        impaired <= 1'b1;
        good_ref <= 3'h0;
      end else if (ref_tick && impaired) begin
        if (good_ref == `TTPG_IMP_RECOVER - 3'd1) begin
          impaired <= 1'b0;
        end
        good_ref <= good_ref + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // phase detector, loop filter and lock state
  // --------------------------------------------------------------------------
  ttpg_lock_state_t state;
  ttpg_lock_state_t next_state;
  logic freerun;
  logic signed [12:0] phase_err;
  logic signed [12:0] abs_err;
  logic signed [11:0] gain;
  logic [3:0] lock_run;

  assign freerun = mode_q | impaired; // [R18]
  assign phase_err = (edge_cnt < 12'd2048) ? $signed({1'b0, edge_cnt}) :
                     $signed({1'b0, edge_cnt}) - $signed(`TTPG_FRAME_EDGES);
  assign abs_err = phase_err[12] ? -phase_err : phase_err;
  assign gain = ctrl[`TTPG_CTRL_FAST] ? `TTPG_GAIN_FAST
                                       : `TTPG_GAIN_SLOW; // [R10]

  always_comb begin
    next_state = state;
    case (state)
      TTPG_FREERUN: begin
        if (!freerun) begin
          next_state = TTPG_ACQUIRE;
        end
      end
      TTPG_ACQUIRE: begin
        if (freerun) begin
          next_state = TTPG_FREERUN;
        end else if (ref_tick && abs_err <= `TTPG_LOCK_WIN &&
                     lock_run == `TTPG_LOCK_RUN - 4'd1) begin
          next_state = TTPG_LOCKED;
        end
      end
      TTPG_LOCKED: begin
        if (freerun) begin
          next_state = TTPG_FREERUN;
        end else if (ref_tick && abs_err > (`TTPG_LOCK_WIN <<< 2)) begin
          next_state = TTPG_ACQUIRE;
        end
      end
      default: next_state = TTPG_FREERUN;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= TTPG_ACQUIRE;
      lock_run <= 4'h0;
      lock_out <= 1'b0;
      impairment_flag_out <= 1'b0;
    end else begin
      state <= next_state;
      lock_out <= next_state == TTPG_LOCKED; // [R9]
      impairment_flag_out <= impaired & ~mode_q; // [R11]
      if (next_state != TTPG_ACQUIRE) begin
        lock_run <= 4'h0;
      end else if (ref_tick) begin
        lock_run <= (abs_err <= `TTPG_LOCK_WIN) ? lock_run + 4'h1 : 4'h0;
      end
    end
  end

  // bang-bang loop: a larger step when fast acquire is enabled
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trim <= 12'sd0;
    end else if (freerun) begin
      trim <= 12'sd0; // [R18]
    end else if (ref_tick && phase_err > 13'sd0) begin
      trim <= (trim - gain < -`TTPG_TRIM_MAX) ? -`TTPG_TRIM_MAX
                                               : trim - gain; // [R10]
    end else if (ref_tick && phase_err < 13'sd0) begin
      trim <= (trim + gain > `TTPG_TRIM_MAX) ? `TTPG_TRIM_MAX
                                              : trim + gain; // [R10]
    end
  end

  // --------------------------------------------------------------------------
  // control, interrupt and read registers
  // --------------------------------------------------------------------------
  assign int_event[`TTPG_INT_LOCK] = next_state == TTPG_LOCKED && !lock_out;
  assign int_event[`TTPG_INT_UNLOCK] = next_state != TTPG_LOCKED && lock_out;
  assign int_event[`TTPG_INT_IMP] = impaired & ~mode_q & ~impairment_flag_out;

  // new events win over a write-one-to-clear in the same cycle
  always_comb begin
    next_int_stat = int_stat;
    if (do_write && w_lane0 && aw_addr == `TTPG_OFS_INT_STAT) begin
      next_int_stat = int_stat & ~w_data[2:0];
    end
    next_int_stat = next_int_stat | int_event;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl <= `TTPG_CTRL_RST;
      int_mask <= `TTPG_INT_MASK_RST;
      int_stat <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq_out <= |(next_int_stat & int_mask);
      if (do_write && w_lane0 && aw_addr == `TTPG_OFS_CTRL) begin
        ctrl <= w_data[3:0];
      end
      if (do_write && w_lane0 && aw_addr == `TTPG_OFS_INT_MASK) begin
        int_mask <= w_data[2:0];
      end
    end
  end

  // read mux; unused upper bits read as zero, trim upper bits are sign copies
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    case ({s_axi_araddr_in[7:2], 2'b00})
      `TTPG_OFS_CTRL: rd_word[3:0] = ctrl;
      `TTPG_OFS_STATUS: rd_word[2:0] = {freerun, impairment_flag_out,
                                        lock_out};
      `TTPG_OFS_INT_STAT: rd_word[2:0] = int_stat;
      `TTPG_OFS_INT_MASK: rd_word[2:0] = int_mask;
      `TTPG_OFS_TRIM: rd_word = {{20{trim[11]}}, trim};
      default: rd_ok = 1'b0;
    endcase
  end
endmodule : ttpg_top

// [verilog/ttpg_defs.svh]
// register map, field positions, reset values and timing counts
`ifndef TTPG_DEFS_SVH
`define TTPG_DEFS_SVH

// --------------------------------------------------------------------------
// clock
// --------------------------------------------------------------------------
`define TTPG_CLK_KHZ 125000

// --------------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------------
`define TTPG_OFS_CTRL 8'h00
`define TTPG_OFS_STATUS 8'h04
`define TTPG_OFS_INT_STAT 8'h08
`define TTPG_OFS_INT_MASK 8'h0c
`define TTPG_OFS_TRIM 8'h10

// control fields and reset value
`define TTPG_CTRL_MODE 0
`define TTPG_CTRL_FAST 1
`define TTPG_CTRL_SEL_LO 2
`define TTPG_CTRL_SEL_HI 3
`define TTPG_CTRL_RST 4'h0

// status fields
`define TTPG_STAT_LOCK 0
`define TTPG_STAT_IMP 1
`define TTPG_STAT_FREE 2

// interrupt fields (status and mask share the layout)
`define TTPG_INT_LOCK 0
`define TTPG_INT_UNLOCK 1
`define TTPG_INT_IMP 2
`define TTPG_INT_MASK_RST 3'h0

// --------------------------------------------------------------------------
// nco phase increments: 2 * f_out / 125 MHz * 2^32 (one tick per edge)
// --------------------------------------------------------------------------
`define TTPG_INC_16M 32'd1125899907
`define TTPG_INC_T1 32'd106102872
`define TTPG_INC_DS2 32'd433757337
`define TTPG_INC_OC3 32'd1335906628

// --------------------------------------------------------------------------
// frame timing in half periods (edges) of the 16.384 MHz clock
// --------------------------------------------------------------------------
`define TTPG_FRAME_EDGES 13'd4096
`define TTPG_EDGE_PS_X2 32768
`define TTPG_F0_NS 244
`define TTPG_SYNC_NS 488
`define TTPG_F8_NS 122
`define TTPG_F16_NS 61
`define TTPG_F0_EDGES 12'(((`TTPG_F0_NS * `TTPG_EDGE_PS_X2) + 999999) / 1000000)
`define TTPG_SYNC_EDGES 12'(((`TTPG_SYNC_NS * `TTPG_EDGE_PS_X2) + 999999) / 1000000)
`define TTPG_F8_EDGES 12'(((`TTPG_F8_NS * `TTPG_EDGE_PS_X2) + 999999) / 1000000)
`define TTPG_F16_EDGES 12'(((`TTPG_F16_NS * `TTPG_EDGE_PS_X2) + 999999) / 1000000)

// --------------------------------------------------------------------------
// reference prescale: falling edges per 8 kHz frame, by rate select code
// --------------------------------------------------------------------------
`define TTPG_DIV_OC3 12'd2430
`define TTPG_DIV_8K 12'd1
`define TTPG_DIV_T1 12'd193
`define TTPG_DIV_2M 12'd256

// --------------------------------------------------------------------------
// loop and monitor constants
// --------------------------------------------------------------------------
`define TTPG_REF_PERIOD_NS 125000
`define TTPG_REF_PERIOD_CYC ((`TTPG_REF_PERIOD_NS * (`TTPG_CLK_KHZ / 1000)) / 1000)
`define TTPG_LOCK_WIN 13'sd16
`define TTPG_LOCK_RUN 4'd8
`define TTPG_GAIN_SLOW 12'sd1
`define TTPG_GAIN_FAST 12'sd16
`define TTPG_TRIM_MAX 12'sd1536
`define TTPG_IMP_RECOVER 3'd4
`define TTPG_RESP_OKAY 2'b00
`define TTPG_RESP_SLVERR 2'b10

`endif

// [verilog/ttpg_pkg.sv]
// shared types of the timing pulse generator
package ttpg_pkg;

  // loop state: searching, locked, or free running on the master clock
  typedef enum logic [1:0] {
    TTPG_ACQUIRE,
    TTPG_LOCKED,
    TTPG_FREERUN
  } ttpg_lock_state_t;

  typedef logic signed [11:0] ttpg_trim_t;
  typedef logic [1:0] ttpg_resp_t;

endpackage : ttpg_pkg

// [verilog/ttpg_nco_if.sv]
// link between the loop control and one numerically controlled oscillator
`timescale 1ns/10ps
interface ttpg_nco_if;
  import ttpg_pkg::*;
  ttpg_trim_t trim;
  logic tick;
  modport core (input trim, output tick);
  modport ctrl (output trim, input tick);
endinterface : ttpg_nco_if

// [verilog/ttpg_nco.sv]
// phase accumulator giving one tick per output clock edge
`timescale 1ns/10ps
`include "ttpg_defs.svh"
module ttpg_nco import ttpg_pkg::*; #(
  parameter logic [31:0] INC = `TTPG_INC_16M
) (
  input wire logic clk_in,
  input wire logic rst_in,
  ttpg_nco_if.core nco
);
  logic [31:0] acc = 32'h0;
  logic signed [24:0] adj;
  logic [31:0] step;
  logic [32:0] sum;

  // too small an increment would zero INC[31:20] and leave the trim with no effect
  if (INC < 32'h0010_0000) begin : g_bad_inc
    $error("ttpg_nco: increment too small");
  end

  // trim steps the frequency by about one part per million each
  assign adj = $signed({1'b0, INC[31:20]}) * nco.trim;
  assign step = INC + {{7{adj[24]}}, adj};
  assign sum = {1'b0, acc} + {1'b0, step};

  // the carry out of the accumulator marks one clock edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc <= 32'h0;
      nco.tick <= 1'b0;
    end else begin
      acc <= sum[31:0];
      nco.tick <= sum[32];
    end
  end
endmodule : ttpg_nco

// [dv/ttpg_chk_sva.sv]
// assertions on the generator's clock and frame outputs
`timescale 1ns/10ps
module ttpg_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_t1_out,
  input wire logic clk_2m_out,
  input wire logic clk_16m_out,
  input wire logic frame_pulse_2m_n_out,
  input wire logic receive_sync_pulse_out,
  input wire logic transmit_sync_pulse_out,
  input wire logic frame_pulse_general_out,
  input wire logic lock_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // frame start as seen on the general pulse
  sequence gen_rise;
    $rose(frame_pulse_general_out);
  endsequence
  // edges jitter by one cycle, so every width gets a small window
  chk_rst_levels: assert property (disable iff (1'b0)
    sys_rst_in |-> clk_t1_out && clk_2m_out && !clk_16m_out &&
    frame_pulse_2m_n_out && !receive_sync_pulse_out && !lock_out)
    else $error("reset levels wrong");
  chk_sync_pair: assert property (
    receive_sync_pulse_out == transmit_sync_pulse_out)
    else $error("sync pulses differ");
  chk_frame_align: assert property (
    gen_rise |-> ##[0:1] (receive_sync_pulse_out && !frame_pulse_2m_n_out))
    else $error("frame pulses misaligned");
  chk_sync_width: assert property (
    $rose(receive_sync_pulse_out) |-> ##[59:63] $fell(receive_sync_pulse_out))
    else $error("sync pulse width wrong");
  chk_f0_width: assert property (
    $fell(frame_pulse_2m_n_out) |-> ##[29:32] $rose(frame_pulse_2m_n_out))
    else $error("2m frame pulse width wrong");
  chk_gen_width: assert property (
    gen_rise |-> ##[14:17] $fell(frame_pulse_general_out))
    else $error("general pulse width wrong");
  chk_clk_2m_half: assert property (
    $rose(clk_2m_out) |-> ##[29:32] $fell(clk_2m_out))
    else $error("2m clock half period wrong");
  chk_clk_t1_half: assert property (
    $rose(clk_t1_out) |-> ##[39:42] $fell(clk_t1_out))
    else $error("t1 clock half period wrong");
endmodule : ttpg_chk

bind ttpg_top ttpg_chk u_chk (.clk_in, .sys_rst_in, .clk_t1_out,
  .clk_2m_out, .clk_16m_out, .frame_pulse_2m_n_out,
  .receive_sync_pulse_out, .transmit_sync_pulse_out,
  .frame_pulse_general_out, .lock_out);

// [dv/ttpg_ref_src.sv]
// reference source standing in for the upstream timing feed
`timescale 1ns/10ps
module ttpg_ref_src #(
  parameter int PER = 256
) (
  input wire logic clk_in,
  input wire logic en_in,
  output logic ref_out = 1'b1
);
  int cnt = 0;
  // one falling edge per period; idles high so a stop leaves no edges
  always_ff @(posedge clk_in) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    ref_out <= !(en_in && cnt == 0);
  end
endmodule : ttpg_ref_src

// [dv/tb_top.sv]
// self-checking bench for the timing pulse generator
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import ttpg_pkg::*;
  // bus, reference and output nets
  logic clk_in = 1'b0, sys_rst_in = 1'b0, ref_en = 1'b1, ref_w;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rd, got;
  logic awr, wr, bv, arr, rv, clk_t1_out, clk_2m_out, clk_4m_out;
  logic clk_8m_out, clk_16m_out, clk_oc3_out, clk_ds2_out, lock_out;
  logic frame_pulse_2m_n_out, receive_sync_pulse_out, irq_out;
  logic transmit_sync_pulse_out, frame_pulse_general_out;
  logic frame_pulse_8m_n_out, impairment_flag_out;
  ttpg_resp_t bresp, rresp, gresp;
  int err_total = 0, cmp_count = 0;
  wire [10:0] rst_lv = {clk_t1_out, clk_2m_out, clk_4m_out, clk_8m_out,
    clk_16m_out, clk_ds2_out, frame_pulse_2m_n_out, frame_pulse_general_out,
    receive_sync_pulse_out, transmit_sync_pulse_out, frame_pulse_8m_n_out};
  // 125 MHz clock
  always #4 clk_in = ~clk_in;
  // short reference period keeps the monitor quick
  ttpg_top #(.REF_PERIOD_CYC(256)) DUT (.clk_in, .sys_rst_in,
    .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .ref_in(ref_w),
    .clk_t1_out, .clk_2m_out, .clk_4m_out, .clk_8m_out, .clk_16m_out,
    .clk_oc3_out, .clk_ds2_out, .frame_pulse_2m_n_out, .lock_out,
    .receive_sync_pulse_out, .transmit_sync_pulse_out, .irq_out,
    .frame_pulse_general_out, .frame_pulse_8m_n_out, .impairment_flag_out);
  ttpg_ref_src #(.PER(256)) u_ref (.clk_in, .en_in(ref_en), .ref_out(ref_w));
  task automatic end_sim();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // one edge of a bounded wait; running out ends the run
  task automatic tick(inout int n);
    @(posedge clk_in);
    n++;
    if (n > 20000) begin
      err_total++;
      end_sim();
    end
  endtask : tick
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_in);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      tick(n);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    gresp = bresp;
    br <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n = 0;
    @(posedge clk_in);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      tick(n);
      if (arr) arv <= 1'b0;
    end while (!rv);
    got = rd;
    gresp = rresp;
    rr <= 1'b0;
  endtask : axi_rd
  task automatic wait_gen(input logic lvl);
    int n = 0;
    while (frame_pulse_general_out !== lvl) tick(n);
  endtask : wait_gen
  // only the 8 kHz code matches the reference, others look impaired
  task automatic t_rates();
    logic [1:0] codes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    foreach (codes[i]) begin
      axi_wr(8'h00, {28'h0, codes[i], 2'h0});
      repeat (2400) @(posedge clk_in);
      `CHK(impairment_flag_out, codes[i] != 2'h1)
      `CHK(lock_out && codes[i] != 2'h1, 1'b0)
    end
  endtask : t_rates
  // impairment event raised at start: masked, unmasked, cleared
  task automatic t_irq();
    axi_rd(8'h08);
    `CHK(got[2], 1'b1)
    `CHK(irq_out, 1'b0)
    axi_wr(8'h0c, 32'h4);
    repeat (2) @(posedge clk_in);
    `CHK(irq_out, 1'b1)
    axi_wr(8'h08, 32'h4);
    repeat (2) @(posedge clk_in);
    `CHK(irq_out, 1'b0)
  endtask : t_irq
  // mode only takes effect at the general pulse rise
  task automatic t_mode();
    wait_gen(1'b1);
    wait_gen(1'b0);
    axi_wr(8'h00, 32'h5);
    axi_rd(8'h04);
    `CHK(got[2], 1'b0)
    wait_gen(1'b1);
    repeat (3) @(posedge clk_in);
    axi_rd(8'h04);
    `CHK(got[2], 1'b1)
    ref_en <= 1'b0;
    repeat (800) @(posedge clk_in);
    `CHK(impairment_flag_out, 1'b0)
    axi_wr(8'h00, 32'h4);
    wait_gen(1'b0);
    wait_gen(1'b1);
    repeat (400) @(posedge clk_in);
    `CHK(impairment_flag_out, 1'b1)
  endtask : t_mode
  // reset in mid-run: fixed levels, but the oc3 clock keeps moving
  task automatic t_reset();
    logic v;
    int n = 0;
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    v = clk_oc3_out;
    repeat (8) begin
      @(posedge clk_in);
      n += int'(clk_oc3_out !== v);
      v = clk_oc3_out;
    end
    `CHK(rst_lv, 11'h799)
    `CHK(n > 1, 1'b1)
    sys_rst_in <= 1'b0;
  endtask : t_reset
  initial begin
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    axi_rd(8'h00);
    `CHK(got, 32'h0)
    axi_rd(8'h14);
    `CHK({gresp, got}, 34'h200000000)
    axi_wr(8'h14, 32'h0);
    `CHK(gresp, 2'h2)
    t_rates();
    t_irq();
    t_mode();
    t_reset();
    end_sim();
  end
endmodule : tb_top
